/* File: src/mcib_capability_bank.sv */
`timescale 1ns/1ns
`default_nettype none
module mcib_capability_bank #(
    parameter mcib_pkg::mcib_caps_s CAPS = mcib_pkg::CAPS_DEFAULT
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire mcib_pkg::mcib_req_s req,
    output logic [7:0] rsp_data,
    output logic rsp_valid,
    output logic rsp_hit,
    output logic wr_refused
);

    // ****************************************************************
    // Decode
    // ****************************************************************
    function automatic logic in_bank(input logic [7:0] page, input logic [7:0] addr);
        return (page == mcib_pkg::PAGE_ID) && (addr >= mcib_pkg::OFS_TYPE) && (addr <= mcib_pkg::OFS_MON_B);
    endfunction : in_bank

    logic rd_hit;
    logic wr_hit;
    assign rd_hit = req.rd && in_bank(req.page, req.addr); // R1
    assign wr_hit = req.wr && in_bank(req.page, req.addr);

    // ****************************************************************
    // Byte image
    // ****************************************************************
    // The image is reloaded from constants on every reset and has no write
    // path, so a host write can never disturb it.
    logic [7:0] image_q [mcib_pkg::NUM_BYTES];
    genvar gi;
    generate
        for (gi = 0; gi < mcib_pkg::NUM_BYTES; gi++) begin : g_img
            localparam logic [7:0] OFS = mcib_pkg::OFS_TYPE + 8'(gi);
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    image_q[gi] <= mcib_pkg::mcib_byte(CAPS, OFS); // R22
                end
            end
        end
    endgenerate

    logic [3:0] idx;
    assign idx = 4'(req.addr - mcib_pkg::OFS_TYPE);

    // ****************************************************************
    // Read answer
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rsp_valid <= 1'b0;
            rsp_hit <= 1'b0;
            rsp_data <= mcib_pkg::READ_MISS;
        end else begin
            rsp_valid <= req.rd;
            if (req.rd) begin
                rsp_hit <= rd_hit;
                rsp_data <= rd_hit ? image_q[idx] : mcib_pkg::READ_MISS; // R1
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_refused <= 1'b0;
        end else begin
            wr_refused <= wr_hit; // R22
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_read_latency: assert property (@(posedge core_clk) disable iff (srst)
        req.rd |=> rsp_valid) else $error("read not answered next cycle"); // R1

    a_page_select: assert property (@(posedge core_clk) disable iff (srst)
        req.rd && req.page != mcib_pkg::PAGE_ID |=> !rsp_hit && rsp_data == 8'h00)
        else $error("read on other page hit the bank"); // R1

    a_type_byte: assert property (@(posedge core_clk) disable iff (srst)
        req.rd && req.page == 8'h00 && req.addr == 8'h80 |=> rsp_data == CAPS.type_id)
        else $error("type byte wrong"); // R2

    a_desc_byte: assert property (@(posedge core_clk) disable iff (srst)
        req.rd && req.page == 8'h00 && req.addr == 8'h81 |=>
        rsp_data[7:6] == CAPS.power_class && rsp_data[5] == CAPS.tx_cdr && rsp_data[3] == CAPS.ref_clk
        && rsp_data[0] == 1'b0) else $error("description byte wrong"); // R3

    a_supply_resv: assert property (@(posedge core_clk) disable iff (srst)
        req.rd && req.page == 8'h00 && req.addr == 8'h82 |=> rsp_data[2:0] == 3'h0 && rsp_data[7:3] == CAPS.supplies)
        else $error("supply byte wrong"); // R7

    a_rate_bytes: assert property (@(posedge core_clk) disable iff (srst)
        req.rd && req.page == 8'h00 && req.addr == 8'h85 |=> rsp_data == CAPS.max_rate)
        else $error("max rate byte wrong"); // R10

    a_wl_msb_first: assert property (@(posedge core_clk) disable iff (srst)
        req.rd && req.page == 8'h00 && req.addr == 8'h86 ##1 req.rd && req.page == 8'h00 && req.addr == 8'h87
        |=> {$past(rsp_data), rsp_data} == CAPS.wavelength) else $error("wavelength order wrong"); // R11

    a_tol_value: assert property (@(posedge core_clk) disable iff (srst)
        req.rd && req.page == 8'h00 && req.addr == 8'h88 |=> rsp_data == CAPS.tolerance[15:8])
        else $error("tolerance high byte wrong"); // R12

    a_flags_resv: assert property (@(posedge core_clk) disable iff (srst)
        req.rd && req.page == 8'h00 && req.addr == 8'h8a |=> rsp_data[1:0] == 2'h0 && rsp_data[7:4] == CAPS.flags)
        else $error("flags byte wrong"); // R13

    a_mon_b_resv: assert property (@(posedge core_clk) disable iff (srst)
        req.rd && req.page == 8'h00 && req.addr == 8'h8c |=> rsp_data[1:0] == 2'h0 && rsp_data[7:2] == CAPS.monitors_b)
        else $error("monitor byte b wrong"); // R20

    a_desc_low_bits: assert property (@(posedge core_clk) disable iff (srst)
        req.rd && req.page == mcib_pkg::PAGE_ID && req.addr == mcib_pkg::OFS_DESC |=>
        rsp_data[4] == CAPS.rx_cdr && rsp_data[2] == CAPS.page2 && rsp_data[1] == CAPS.ctl_launch)
        else $error("description low bits wrong"); // R4

    a_case_temp_byte: assert property (@(posedge core_clk) disable iff (srst)
        req.rd && req.page == mcib_pkg::PAGE_ID && req.addr == mcib_pkg::OFS_MAX_CASE_TEMPERATURE |=> rsp_data == CAPS.max_case_temp)
        else $error("case temperature byte wrong"); // R8

    a_min_rate_byte: assert property (@(posedge core_clk) disable iff (srst)
        req.rd && req.page == mcib_pkg::PAGE_ID && req.addr == mcib_pkg::OFS_MIN_RATE |=> rsp_data == CAPS.min_rate)
        else $error("min rate byte wrong"); // R9

    a_tol_low_byte: assert property (@(posedge core_clk) disable iff (srst)
        req.rd && req.page == mcib_pkg::PAGE_ID && req.addr == mcib_pkg::OFS_TOL_LO |=> rsp_data == CAPS.tolerance[7:0])
        else $error("tolerance low byte wrong"); // R12

    a_squelch_bits: assert property (@(posedge core_clk) disable iff (srst)
        req.rd && req.page == mcib_pkg::PAGE_ID && req.addr == mcib_pkg::OFS_FLAGS |=>
        rsp_data[3] == CAPS.squelch && rsp_data[2] == CAPS.alarm_warn)
        else $error("squelch or alarm bits wrong"); // R14

    a_mon_a_byte: assert property (@(posedge core_clk) disable iff (srst)
        req.rd && req.page == mcib_pkg::PAGE_ID && req.addr == mcib_pkg::OFS_MON_A |=> rsp_data == CAPS.monitors_a)
        else $error("monitor byte a wrong"); // R16

    a_range_miss: assert property (@(posedge core_clk) disable iff (srst)
        req.rd && (req.addr < mcib_pkg::OFS_TYPE || req.addr > mcib_pkg::OFS_MON_B) |=> !rsp_hit && rsp_data == 8'h00)
        else $error("read outside the bank hit"); // R1

    a_refused_pulse: assert property (@(posedge core_clk) disable iff (srst)
        wr_hit |=> wr_refused) else $error("in-bank write not flagged"); // R22

    a_valid_pulse: assert property (@(posedge core_clk) disable iff (srst)
        !req.rd |=> !rsp_valid) else $error("answer without a read"); // R1

    a_write_no_effect: assert property (@(posedge core_clk) disable iff (srst)
        wr_hit ##1 req.rd && req.page == 8'h00 && req.addr == $past(req.addr)
        |=> rsp_data == mcib_pkg::mcib_byte(CAPS, $past(req.addr, 2)))
        else $error("write changed a read-only byte"); // R22

    a_write_flag: assert property (@(posedge core_clk) disable iff (srst)
        wr_refused |-> $past(req.wr) && $past(req.page) == 8'h00) else $error("spurious write flag"); // R22

endmodule : mcib_capability_bank
`default_nettype wire

/* File: src/mcib_pkg.sv */
// Behaviour
// [R1] Bytes appear only on upper page zero; host selects it before reading 128-140.
// [R2] Byte 128 returns module type identifier, zero when unspecified.
// [R3] Byte 129 bits 7-6 encode power class 1 to 4.
// [R4] Byte 129 bits 5 and 4 flag transmit and receive clock_data_recovery stages.
// [R5] Byte 129 bit 3 is one only when an external reference clock is needed.
// [R6] Byte 129 bit 2 flags page 02, bit 1 controlled launch, bit 0 reserved.
// [R7] Byte 130 bits 7-3 flag required supplies; bits 2-0 reserved.
// [R8] Byte 131 holds maximum case_temperature in whole degrees Celsius.
// [R9] Byte 132 is minimum lane rate in 100 Mb/s steps, zero unknown.
// [R10] Byte 133 is maximum lane rate in 100 Mb/s steps, zero unknown.
// [R11] Bytes 134-135 hold centre wavelength times 20, zero when unused.
// [R12] Bytes 136-137 hold wavelength tolerance times 200, zero when unused.
// [R13] Byte 138 bits 7-4 flag fault, loss_of_signal and loss_of_lock flags.
// [R14] Byte 138 bit 3 flags automatic squelch on loss_of_signal.
// [R15] Byte 138 bit 2 flags alarm and warning monitors; bits 1-0 reserved.
// [R16] Byte 139 bits 7 and 6 flag bias and launched_power monitors.
// [R17] Byte 139 bit 5 flags individual per-channel receive power monitors.
// [R18] Byte 139 bit 4 is one for average_power, zero for modulation_amplitude.
// [R19] Byte 139 bits 3-0 flag temperature and elapsed-time monitors.
// [R20] Byte 140 bit 7 bit_error_ratio, bit 2 thermoelectric_cooler current; 1-0 reserved.
// [R21] Byte 140 bits 6-3 flag internal supply rail monitors.
// [R22] Whole range is read-only, writes change nothing, reserved bits read zero.
// [R23] Host reads two-byte fields with lower address as most significant byte.
package mcib_pkg;

    // ****************************************************************
    // Map
    // ****************************************************************
    localparam logic [7:0] PAGE_ID = 8'h00;
    localparam logic [7:0] OFS_TYPE = 8'h80;
    localparam logic [7:0] OFS_DESC = 8'h81;
    localparam logic [7:0] OFS_SUPPLY = 8'h82;
    localparam logic [7:0] OFS_MAX_CASE_TEMPERATURE = 8'h83;
    localparam logic [7:0] OFS_MIN_RATE = 8'h84;
    localparam logic [7:0] OFS_MAX_RATE = 8'h85;
    localparam logic [7:0] OFS_WL_HI = 8'h86;
    localparam logic [7:0] OFS_WL_LO = 8'h87;
    localparam logic [7:0] OFS_TOL_HI = 8'h88;
    localparam logic [7:0] OFS_TOL_LO = 8'h89;
    localparam logic [7:0] OFS_FLAGS = 8'h8a;
    localparam logic [7:0] OFS_MON_A = 8'h8b;
    localparam logic [7:0] OFS_MON_B = 8'h8c;
    localparam int NUM_BYTES = 13;
    localparam logic [7:0] RESV_DESC = 8'h01;
    localparam logic [7:0] RESV_SUPPLY = 8'h07;
    localparam logic [7:0] RESV_FLAGS = 8'h03;
    localparam logic [7:0] RESV_MON_B = 8'h03;
    localparam logic [7:0] READ_MISS = 8'h00;

    typedef enum logic [1:0] {
        MCIB_PWR_CLASS1 = 2'h0,
        MCIB_PWR_CLASS2 = 2'h1,
        MCIB_PWR_CLASS3 = 2'h2,
        MCIB_PWR_CLASS4 = 2'h3
    } mcib_pwr_e;

    typedef struct packed {
        logic [7:0] type_id;
        mcib_pwr_e power_class;
        logic tx_cdr;
        logic rx_cdr;
        logic ref_clk;
        logic page2;
        logic ctl_launch;
        logic [4:0] supplies;
        logic [7:0] max_case_temp;
        logic [7:0] min_rate;
        logic [7:0] max_rate;
        logic [15:0] wavelength;
        logic [15:0] tolerance;
        logic [3:0] flags;
        logic squelch;
        logic alarm_warn;
        logic [7:0] monitors_a;
        logic [5:0] monitors_b;
    } mcib_caps_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mcib_req_s;

    localparam mcib_caps_s CAPS_DEFAULT = '{
        type_id: 8'h00, power_class: MCIB_PWR_CLASS2, tx_cdr: 1'b0, rx_cdr: 1'b0,
        ref_clk: 1'b0, page2: 1'b0, ctl_launch: 1'b0, supplies: 5'h18,
        max_case_temp: 8'h46, min_rate: 8'h00, max_rate: 8'h32,
        wavelength: 16'h4268, tolerance: 16'h0fa0, flags: 4'h6, squelch: 1'b1,
        alarm_warn: 1'b1, monitors_a: 8'hc8, monitors_b: 6'h0c
    };

    function automatic logic [7:0] mcib_byte(input mcib_caps_s c, input logic [7:0] ofs);
        logic [7:0] b;
        b = 8'h00;
        if (ofs == OFS_TYPE) begin
            b = c.type_id; // R2
        end else if (ofs == OFS_DESC) begin
            b = {c.power_class, c.tx_cdr, c.rx_cdr, c.ref_clk, c.page2, c.ctl_launch, 1'b0}; // R3 R4 R5 R6
        end else if (ofs == OFS_SUPPLY) begin
            b = {c.supplies, 3'h0}; // R7
        end else if (ofs == OFS_MAX_CASE_TEMPERATURE) begin
            b = c.max_case_temp; // R8
        end else if (ofs == OFS_MIN_RATE) begin
            b = c.min_rate; // R9
        end else if (ofs == OFS_MAX_RATE) begin
            b = c.max_rate; // R10
        end else if (ofs == OFS_WL_HI) begin
            b = c.wavelength[15:8]; // R11 R23
        end else if (ofs == OFS_WL_LO) begin
            b = c.wavelength[7:0]; // R11
        end else if (ofs == OFS_TOL_HI) begin
            b = c.tolerance[15:8]; // R12 R23
        end else if (ofs == OFS_TOL_LO) begin
            b = c.tolerance[7:0]; // R12
        end else if (ofs == OFS_FLAGS) begin
            b = {c.flags, c.squelch, c.alarm_warn, 2'h0}; // R13 R14 R15
        end else if (ofs == OFS_MON_A) begin
            b = c.monitors_a; // R16 R17 R18 R19
        end else if (ofs == OFS_MON_B) begin
            b = {c.monitors_b, 2'h0}; // R20 R21
        end
        return b;
    endfunction : mcib_byte

endpackage : mcib_pkg

/* File: verif/mcib_capability_bank_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module mcib_capability_bank_tb;
    // Fields are non-zero except rx_cdr, page2, min_rate and alarm_warn, so a dropped bit or shifted field shows up.
    localparam mcib_pkg::mcib_caps_s CAPS = '{
        type_id: 8'h5a, power_class: mcib_pkg::MCIB_PWR_CLASS4, tx_cdr: 1'b1, rx_cdr: 1'b0,
        ref_clk: 1'b1, page2: 1'b0, ctl_launch: 1'b1, supplies: 5'h1f, max_case_temp: 8'h55,
        min_rate: 8'h00, max_rate: 8'h64, wavelength: 16'h4268, tolerance: 16'h0fa1,
        flags: 4'ha, squelch: 1'b1, alarm_warn: 1'b0, monitors_a: 8'ha5, monitors_b: 6'h3d
    };
    logic core_clk;
    logic srst;
    mcib_pkg::mcib_req_s req;
    logic [7:0] rsp_data;
    logic rsp_valid;
    logic rsp_hit;
    logic wr_refused;
    int fails;
    int checks_done;
    logic [31:0] seed;
    logic [7:0] seen [256];

    mcib_host_model host (.req(req));
    mcib_capability_bank #(.CAPS(CAPS)) uut (.core_clk(core_clk), .srst(srst), .req(req),
        .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .wr_refused(wr_refused));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic int exp_byte(input int a);
        case (a)
            128: return CAPS.type_id;
            129: return int'(CAPS.power_class) * 64 + CAPS.tx_cdr * 32 + CAPS.rx_cdr * 16 + CAPS.ref_clk * 8
                        + CAPS.page2 * 4 + CAPS.ctl_launch * 2;
            130: return CAPS.supplies * 8;
            131: return CAPS.max_case_temp;
            132: return CAPS.min_rate;
            133: return CAPS.max_rate;
            134: return CAPS.wavelength / 256;
            135: return CAPS.wavelength % 256;
            136: return CAPS.tolerance / 256;
            137: return CAPS.tolerance % 256;
            138: return CAPS.flags * 16 + CAPS.squelch * 8 + CAPS.alarm_warn * 4;
            139: return CAPS.monitors_a;
            140: return CAPS.monitors_b * 4;
            default: return 0;
        endcase
    endfunction : exp_byte

    task automatic cmp(input logic [15:0] got, input logic [15:0] want, input string m);
        checks_done++;
        if (got !== want) begin
            fails++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, got, want);
        end
    endtask : cmp

    // One request launched at a falling edge, its answer looked at one cycle later.
    task automatic step(input logic rd, input logic wr, input logic [7:0] pg, input logic [7:0] ad,
                        input logic [7:0] wd);
        logic hit;
        hit = (pg == 8'h00) && (ad >= 8'h80) && (ad <= 8'h8c);
        host.drive(rd, wr, pg, ad, wd);
        @(negedge core_clk);
        cmp(16'(rsp_valid), 16'(rd), "valid");
        cmp(16'(wr_refused), 16'(wr && hit), "refused");
        if (rd) begin
            cmp(16'(rsp_hit), 16'(hit), "hit");
            cmp(16'(rsp_data), hit ? 16'(exp_byte(int'(ad))) : 16'h0000, "data");
            if (hit) seen[ad] = rsp_data;
        end
    endtask : step

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop

    initial begin
        #20000;
        fails++;
        report_and_stop();
    end

    initial begin
        srst = 1'b1;
        fails = 0;
        checks_done = 0;
        seed = 32'h0001341c;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        srst <= 1'b0;
        for (int pass = 0; pass < 2; pass++) begin
            for (int a = 8'h7e; a <= 8'h8e; a++) step(1'b1, pass == 0, 8'h00, 8'(a), 8'hff);
        end
        cmp(host.wide16(seen[8'h86], seen[8'h87]), CAPS.wavelength, "wavelength");
        cmp(host.wide16(seen[8'h88], seen[8'h89]), CAPS.tolerance, "tolerance");
        for (int i = 0; i < 400; i++) begin
            seed = lfsr(seed);
            step(seed[0], seed[1], seed[2] ? 8'h00 : seed[15:8], 8'h78 + {3'h0, seed[20:16]}, seed[31:24]);
        end
        srst <= 1'b1;
        @(negedge core_clk);
        cmp({rsp_data, 6'h0, rsp_valid, rsp_hit}, 16'h0000, "reset");
        srst <= 1'b0;
        step(1'b1, 1'b0, 8'h00, 8'h8c, 8'h00);
        step(1'b1, 1'b1, 8'h01, 8'h80, 8'h00);
        step(1'b0, 1'b1, 8'h00, 8'h86, 8'h00);
        step(1'b1, 1'b0, 8'h00, 8'h86, 8'hff);
        host.drive(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        report_and_stop();
    end
endmodule : mcib_capability_bank_tb
`default_nettype wire

/* File: verif/mcib_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module mcib_host_model (
    output var mcib_pkg::mcib_req_s req
);
    initial req = '0;
    // The page travels with every request, so the caller picks the page, zero or another, for each read.
    task automatic drive(input logic rd, input logic wr, input logic [7:0] pg, input logic [7:0] ad,
                         input logic [7:0] wd);
        req <= '{rd: rd, wr: wr, page: pg, addr: ad, wdata: wd};
    endtask : drive
    function automatic logic [15:0] wide16(input logic [7:0] low_addr_byte, input logic [7:0] high_addr_byte);
        return {low_addr_byte, high_addr_byte};
    endfunction : wide16
endmodule : mcib_host_model
`default_nettype wire
